/* bench/photo_source.sv */
// model of the analog front end that feeds modulator samples to the timing block
// assumes the system clock; the bench picks a steady light level
`timescale 1ns/100ps
`default_nettype none
module photo_source (
  input wire logic clk_i,
  input wire logic level_i,
  output logic photo_o
);
  // registered so a level change never lands mid-edge; steady light makes counts predictable
  always_ff @(posedge clk_i)
    photo_o <= level_i;
endmodule
`default_nettype wire

/* bench/tb_light_adc_timing.sv */
// self-checking bench for the light adc timing block over classic wishbone
// assumes the block's register offsets header and a fast oscillator divider
`timescale 1ns/100ps
`default_nettype none
`include "light_adc_consts.svh"
module tb_light_adc_timing;
  localparam int DIV = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic level = 1'b1;
  logic ack_o;
  logic [31:0] dat_o;
  logic photo;
  logic [15:0] range_const_o;
  logic integrating_o;
  logic conv_done_o;
  logic [15:0] rc [4] = '{16'h03cd, 16'h0f34, 16'h3cd0, 16'hf340};
  logic [31:0] t;
  logic [31:0] r;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int c;

  light_adc_timing #(.OSC_DIV(DIV)) u_light_adc_timing (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(wdat), .sel_i(4'hf), .we_i(we), .cyc_i(cyc), .stb_i(stb), .ack_o(ack_o), .dat_o(dat_o),
    .photo_i(photo), .range_const_o(range_const_o), .integrating_o(integrating_o),
    .conv_done_o(conv_done_o));
  photo_source u_photo_source (.clk_i(clk_i), .level_i(level), .photo_o(photo));

  always #2 clk_i = ~clk_i;

  // hang guard: well above the longest expected run of about 40k cycles
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done;
    if (bad_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one classic cycle; ack and read data are taken right after the rising edge, before the slave's registers move
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    chk("ack", 32'h1, {31'h0, ack_o});
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(name, exp, q);
  endtask

  // counts cycles up to the next conversion pulse
  task automatic wait_done(output int n);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (conv_done_o !== 1'b1 && n < 70000);
  endtask

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`REG_CMD, 32'h0, "cmd");
    rd(`REG_RESULT, 32'h0, "result");
    rd(`REG_TIMER, 32'h0, "timer");
    rd(8'h3c, 32'h0, "unmapped");
    rd(`REG_STATUS, 32'h0002_0000, "status_idle");
    // every gain code picks its own scaling constant at once
    for (int g = 0; g < 4; g++)
    begin
      wr(`REG_CTRL, 32'(g) << `CTRL_GAIN_LSB);
      chk("range_const", {16'h0, rc[g]}, {16'h0, range_const_o});
      rd(`REG_CTRL, 32'(g) << `CTRL_GAIN_LSB, "ctrl");
    end
    // internal timing, fast oscillator, widths 16, 256 and 4096 oscillator ticks
    wr(`REG_CTRL, 32'h08);
    for (int w = 3; w > 0; w--)
    begin
      wr(`REG_CMD, 32'h80 | 32'(w));
      wait_done(c);
      wait_done(c);
      chk("period", (32'h10 << (4 * (3 - w))) * DIV, 32'(c));
      rd(`REG_RESULT, 32'h10 << (4 * (3 - w)), "full_scale");
    end
    // gain zero halves the oscillator, so the period doubles
    wr(`REG_CTRL, 32'h0);
    wr(`REG_CMD, 32'h83);
    wait_done(c);
    wait_done(c);
    chk("half_period", 32'h10 * 2 * DIV, 32'(c));
    level <= 1'b0;
    wait_done(c);
    wait_done(c);
    rd(`REG_RESULT, 32'h0, "dark");
    // external timing: waits for a boundary, then counts ticks up to the next one
    level <= 1'b1;
    wr(`REG_CTRL, 32'h08);
    wr(`REG_CMD, 32'ha0);
    repeat (20) @(posedge clk_i);
    chk("ext_idle", 32'h0, {31'h0, integrating_o});
    rd(`REG_STATUS, 32'h0004_0000, "status_wait");
    wr(`REG_SYNC, 32'h1);
    chk("ext_run", 32'h1, {31'h0, integrating_o});
    repeat (400) @(posedge clk_i);
    wr(`REG_SYNC, 32'h1);
    repeat (4) @(posedge clk_i);
    wb(1'b0, `REG_TIMER, 32'h0, t);
    wb(1'b0, `REG_RESULT, 32'h0, r);
    chk("timer_range", 32'h1, {31'h0, t >= 32'd99 && t <= 32'd102});
    chk("ext_result", t, r);
    test_done();
  end
endmodule
`default_nettype wire

/* hw/light_adc_timing.sv */
// integration timing of the light sensor adc with a wishbone register file
// assumes classic wishbone, a synchronous photo sample and one 250 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "light_adc_consts.svh"
module light_adc_timing
  import light_adc_pkg::*;
#(
  parameter int OSC_DIV = `OSC_DIV_FAST
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic [31:0] dat_o,
  input wire logic photo_i,
  output logic [15:0] range_const_o,
  output logic integrating_o,
  output logic conv_done_o
);
  cfg_type cfg_q, cfg_d;
  localparam logic [7:0] CMD_INIT = `CMD_RESET;
  localparam logic [7:0] CTRL_INIT = `CTRL_RESET;
  localparam cfg_type CFG_INIT = '{CMD_INIT[`CMD_EN_BIT], CMD_INIT[`CMD_EXT_BIT],
    CMD_INIT[`CMD_WIDTH_LSB +: 2], CTRL_INIT[`CTRL_GAIN_LSB +: 2]}; // fields picked out of the reset words
  state_type state_q, state_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [15:0] range_q, range_d;
  logic [16:0] count_q, count_d;
  logic [15:0] acc_q, acc_d;
  logic [15:0] result_q, result_d;
  logic [15:0] timer_q, timer_d;
  logic done_q, done_d;
  logic req, wr, cfg_wr, sync_wr, tick, int_end, ext_end;
  logic [16:0] cnt_now, period;
  logic [15:0] acc_now;

  function automatic logic [16:0] width_cycles(input logic [1:0] w);
    case (w)
      2'b00: width_cycles = `WIDTH_CYC_00;
      2'b01: width_cycles = `WIDTH_CYC_01;
      2'b10: width_cycles = `WIDTH_CYC_10;
      default: width_cycles = `WIDTH_CYC_11;
    endcase
  endfunction

  function automatic logic [15:0] range_const(input logic [1:0] g);
    case (g)
      2'b00: range_const = `RANGE_CONST_1;
      2'b01: range_const = `RANGE_CONST_2;
      2'b10: range_const = `RANGE_CONST_3;
      default: range_const = `RANGE_CONST_4;
    endcase
  endfunction

  // a full 2^16 count does not fit sixteen bits, so it pins at the top code
  function automatic logic [15:0] sat16(input logic [16:0] v);
    sat16 = v[16] ? 16'hffff : v[15:0];
  endfunction

  // oscillator tick, slowed down in the two low gain ranges
  osc_divider #(
    .DIV(OSC_DIV)
  ) u_osc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .half_i(!cfg_q.gain[1]),
    .tick_o(tick)
  );

  // wishbone decode: writes act on the first cycle of a request, ack follows one cycle later
  always_comb
  begin
    req = cyc_i && stb_i && !ack_q;
    wr = req && we_i && sel_i[0];
    cfg_wr = wr && (adr_i == `REG_CMD || adr_i == `REG_CTRL);
    sync_wr = wr && adr_i == `REG_SYNC && dat_i[`SYNC_BIT];
    cfg_d = cfg_q;
    if (wr && adr_i == `REG_CMD)
    begin
      cfg_d.enable = dat_i[`CMD_EN_BIT];
      cfg_d.ext_mode = dat_i[`CMD_EXT_BIT];
      cfg_d.width = dat_i[`CMD_WIDTH_LSB +: 2];
    end
    if (wr && adr_i == `REG_CTRL)
      cfg_d.gain = dat_i[`CTRL_GAIN_LSB +: 2];
    range_d = range_const(cfg_d.gain);
    ack_d = req;
    dat_d = 32'h0000_0000;
    if (req && !we_i)
    begin
      case (adr_i)
        `REG_CMD: dat_d[7:0] = {cfg_q.enable, 1'b0, cfg_q.ext_mode, 3'b000, cfg_q.width};
        `REG_CTRL: dat_d[7:0] = {4'h0, cfg_q.gain, 2'b00};
        `REG_RESULT: dat_d[15:0] = result_q;
        `REG_TIMER: dat_d[15:0] = timer_q;
        `REG_STATUS: dat_d = {12'h000, state_q, count_q};
        default: dat_d = 32'h0000_0000;
      endcase
    end
  end

  // integration sequencer; a tick and a closing boundary in one cycle both count
  always_comb
  begin
    period = width_cycles(cfg_q.width);
    cnt_now = count_q;
    acc_now = acc_q;
    if (tick && state_q == ST_INTEG && count_q != 17'h10000)
    begin
      cnt_now = count_q + 17'h00001;
      acc_now = (photo_i && acc_q != 16'hffff) ? acc_q + 16'h0001 : acc_q;
    end
    int_end = state_q == ST_INTEG && !cfg_q.ext_mode && tick && cnt_now == period;
    ext_end = state_q == ST_INTEG && cfg_q.ext_mode && sync_wr;
    state_d = state_q;
    count_d = cnt_now;
    acc_d = acc_now;
    result_d = result_q;
    timer_d = timer_q;
    done_d = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        count_d = 17'h00000;
        acc_d = 16'h0000;
        if (cfg_q.enable)
          state_d = cfg_q.ext_mode ? ST_WAIT : ST_INTEG;
      end
      ST_WAIT:
      begin
        count_d = 17'h00000;
        acc_d = 16'h0000;
        if (sync_wr)
          state_d = ST_INTEG;
      end
      ST_INTEG:
      begin
        if (int_end || ext_end)
        begin
          result_d = acc_now;
          if (ext_end)
            timer_d = sat16(cnt_now);
          count_d = 17'h00000;
          acc_d = 16'h0000;
          done_d = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // a new configuration abandons the integration in flight
    if (cfg_wr || !cfg_q.enable)
      state_d = ST_IDLE;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_q <= CFG_INIT;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      range_q <= `RANGE_CONST_1;
      state_q <= ST_IDLE;
      count_q <= 17'h00000;
      acc_q <= 16'h0000;
      result_q <= 16'h0000;
      timer_q <= 16'h0000;
      done_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
      range_q <= range_d;
      state_q <= state_d;
      count_q <= count_d;
      acc_q <= acc_d;
      result_q <= result_d;
      timer_q <= timer_d;
      done_q <= done_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign range_const_o = range_q;
  assign integrating_o = (state_q == ST_INTEG);
  assign conv_done_o = done_q;

  // helper: cycles since the last tick and whether the rate held steady meanwhile
  logic [15:0] gap_q;
  logic steady_q, seen_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gap_q <= 16'h0000;
      steady_q <= 1'b0;
      seen_q <= 1'b0;
    end
    else
    begin
      gap_q <= tick ? 16'h0000 : gap_q + 16'h0001;
      steady_q <= tick ? 1'b1 : steady_q && (cfg_d.gain[1] == cfg_q.gain[1]);
      seen_q <= seen_q || tick;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_restart;
    ##1 (state_q == ST_INTEG && count_q == 17'h00000 && conv_done_o);
  endsequence

  property p_mode_wait;
    state_q == ST_WAIT |-> cfg_q.ext_mode && !integrating_o;
  endproperty
  a_mode_wait: assert property (p_mode_wait) else $error("waiting for sync in internal mode");

  property p_period;
    int_end |-> cnt_now == width_cycles(cfg_q.width) && !cfg_q.ext_mode;
  endproperty
  a_period: assert property (p_period) else $error("internal period length wrong");

  property p_width_bound;
    state_q == ST_INTEG && !cfg_q.ext_mode |-> count_q < width_cycles(cfg_q.width);
  endproperty
  a_width_bound: assert property (p_width_bound) else $error("count passed the width setting");

  property p_half_rate;
    tick && steady_q && seen_q |-> gap_q == (cfg_q.gain[1] ? 16'(OSC_DIV - 1) : 16'(2 * OSC_DIV - 1));
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("oscillator tick spacing wrong");

  property p_full_scale;
    int_end |=> {1'b0, result_q} <= $past(period);
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("internal result above full scale");

  property p_ext_count;
    state_q == ST_INTEG && cfg_q.ext_mode && tick && !ext_end && !cfg_wr && count_q < 17'h10000
      |=> count_q == $past(count_q) + 17'h00001;
  endproperty
  a_ext_count: assert property (p_ext_count) else $error("timer count missed an oscillator tick");

  property p_timer_store;
    ext_end && !cfg_wr |=> timer_q == sat16($past(cnt_now)) && conv_done_o;
  endproperty
  a_timer_store: assert property (p_timer_store) else $error("timer register not loaded at sync");

  property p_range;
    range_const_o == range_const(cfg_q.gain);
  endproperty
  a_range: assert property (p_range) else $error("scaling constant does not follow gain");

  property p_result;
    (int_end || ext_end) && !cfg_wr |=> result_q == $past(acc_now) && conv_done_o;
  endproperty
  a_result: assert property (p_result) else $error("result not updated at integration end");

  property p_restart;
    int_end && cfg_q.enable && !cfg_wr |-> s_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("next integration did not start at once");
endmodule
`default_nettype wire

/* hw/osc_divider.sv */
// conversion oscillator as a one-cycle tick derived from the system clock
// assumes a synchronous active-high reset; half_i halves the tick rate
`timescale 1ns/100ps
`default_nettype none
module osc_divider #(
  parameter int DIV = 381
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic half_i,
  output logic tick_o
);
  localparam logic [15:0] LIM_FAST = 16'(DIV - 1);
  localparam logic [15:0] LIM_SLOW = 16'(2 * DIV - 1);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] lim;

  // slow ranges wait twice as long between ticks
  always_comb
  begin
    lim = half_i ? LIM_SLOW : LIM_FAST;
    tick_o = (cnt_q >= lim);
    cnt_d = tick_o ? 16'h0000 : cnt_q + 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_d;
  end
endmodule
`default_nettype wire

/* pkg/light_adc_consts.svh */
// register offsets, field positions, reset values and timing counts of the light adc timing block
// assumes a 250 MHz system clock and a classic wishbone slave with byte addresses
`ifndef LIGHT_ADC_CONSTS_SVH
`define LIGHT_ADC_CONSTS_SVH
`define REG_CMD 8'h00
`define REG_CTRL 8'h04
`define REG_RESULT 8'h08
`define REG_TIMER 8'h0c
`define REG_SYNC 8'h10
`define REG_STATUS 8'h14
`define CMD_EN_BIT 7
`define CMD_EXT_BIT 5
`define CMD_WIDTH_LSB 0
`define CTRL_GAIN_LSB 2
`define SYNC_BIT 0
`define CMD_RESET 8'h00
`define CTRL_RESET 8'h00
`define WIDTH_CYC_00 17'h10000
`define WIDTH_CYC_01 17'h01000
`define WIDTH_CYC_10 17'h00100
`define WIDTH_CYC_11 17'h00010
`define RANGE_CONST_1 16'h03cd
`define RANGE_CONST_2 16'h0f34
`define RANGE_CONST_3 16'h3cd0
`define RANGE_CONST_4 16'hf340
`define CLK_FREQ_KHZ 250000
`define OSC_FAST_KHZ 655
`define OSC_DIV_FAST (`CLK_FREQ_KHZ / `OSC_FAST_KHZ)
`endif

/* pkg/light_adc_pkg.sv */
// types shared by the light adc timing block
// assumes nothing beyond a SystemVerilog compiler
package light_adc_pkg;
  typedef struct packed {
    logic enable;
    logic ext_mode;
    logic [1:0] width;
    logic [1:0] gain;
  } cfg_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_INTEG = 3'b100
  } state_type;
endpackage
